// >>> core/mtcs_crc32.sv
// module: byte-wide ethernet crc-32 accumulator
`timescale 1ns/1ps
module mtcs_crc32 (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // control and data
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // running remainder
  output logic [31:0]      crc
);
  import mtcs_pkg::*;

  mtcs_crc_st_t st_r;
  mtcs_crc_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (init) begin
      st_nxt.rem = CRC_INIT;
    end else if (en) begin
      for (int i = 0; i < 8; i++) begin
        if (st_nxt.rem[0] ^ data[i]) begin
          st_nxt.rem = (st_nxt.rem >> 1) ^ CRC_POLY;
        end else begin
          st_nxt.rem = st_nxt.rem >> 1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.rem <= CRC_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign crc = st_r.rem;
endmodule : mtcs_crc32

// >>> core/mtcs_pkg.sv
// package: constants, types and carriers of the transmit control and status block
package mtcs_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned CTL_IDX = 0;
  localparam int unsigned STS_IDX = 2;
  localparam int unsigned INT_IDX = 4;
  localparam int unsigned MSK_IDX = 5;
  localparam int unsigned RUN_IDX = 6;
  localparam logic [7:0] CTL_ADDR = 8'(CTL_IDX * 4);
  localparam logic [7:0] STS_ADDR = 8'(STS_IDX * 4);
  localparam logic [7:0] INT_ADDR = 8'(INT_IDX * 4);
  localparam logic [7:0] MSK_ADDR = 8'(MSK_IDX * 4);
  localparam logic [7:0] RUN_ADDR = 8'(RUN_IDX * 4);
  // transmit control fields
  localparam int unsigned CTL_RUN_BIT = 0;
  localparam int unsigned CTL_CRC_BIT = 1;
  localparam int unsigned CTL_PAD_BIT = 2;
  localparam int unsigned CTL_FC_BIT  = 3;
  localparam int unsigned CTL_RSV_LO  = 13;
  // transmit status fields
  localparam int unsigned STS_FID_LO = 0;
  localparam int unsigned STS_MC_BIT = 12;
  localparam int unsigned STS_LC_BIT = 13;
  localparam int unsigned STS_UR_BIT = 14;
  // run register fields
  localparam int unsigned RUN_ACT_BIT   = 0;
  localparam int unsigned RUN_FATAL_BIT = 1;
  localparam int unsigned RUN_EN_BIT    = 2;
  localparam int unsigned RUN_RESTART_BIT = 0;
  // interrupt status / mask fields
  localparam int unsigned INT_W      = 5;
  localparam int unsigned INT_DONE   = 0;
  localparam int unsigned INT_UR     = 1;
  localparam int unsigned INT_LC     = 2;
  localparam int unsigned INT_MC     = 3;
  localparam int unsigned INT_PAUSE  = 4;
  // frame sizes in bytes, crc polynomial and preset
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] FCS_LEN   = 16'h0004;
  localparam logic [31:0] CRC_POLY  = 32'hedb88320;
  localparam logic [31:0] CRC_INIT  = 32'hffffffff;
  // reset values
  localparam logic [5:0]  FID_RST = 6'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] RD_RST  = 32'h00000000;

  typedef enum logic [1:0] {S_IDLE, S_DATA, S_PAD, S_FCS} mtcs_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mtcs_apb_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic [5:0] fid;
  } mtcs_qin_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } mtcs_tx_t;

  typedef struct packed {
    logic [31:0] rem;
  } mtcs_crc_st_t;

  typedef struct packed {
    logic              ctl_run;
    logic              ctl_crc;
    logic              ctl_pad;
    logic              ctl_fc;
    logic [1:0]        ctl_rsv;
    logic [5:0]        txs_fid;
    logic              txs_ur;
    logic              txs_lc;
    logic              txs_mc;
    logic [INT_W-1:0]  int_sts;
    logic [INT_W-1:0]  int_msk;
    mtcs_state_t       state;
    logic [15:0]       cnt;
    logic [1:0]        fcs_idx;
    logic              fatal;
    logic              lc_seen;
    logic [5:0]        cur_fid;
    logic              cur_crc;
    logic              cur_pad;
    logic              near_q;
    logic              q_ready;
    mtcs_tx_t          tx;
    logic              pause_req;
    logic              bkpr;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } mtcs_st_t;
endpackage : mtcs_pkg

// >>> core/mtcs_top.sv
// module: transmit control, framing and status with apb registers
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module mtcs_top (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  // apb slave
  input  wire mtcs_pkg::mtcs_apb_req_t apb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // frame bytes from the queue manager
  input  wire mtcs_pkg::mtcs_qin_t     qin,
  output logic                         q_ready,
  // byte stream to the phy
  output mtcs_pkg::mtcs_tx_t           tx,
  // link state and collisions
  input  wire logic                    full_duplex,
  input  wire logic                    coll_late,
  input  wire logic                    coll_max,
  // flow control
  input  wire logic                    rx_near_full,
  output logic                         pause_req,
  output logic                         backpressure,
  // interrupt
  output logic                         irq
);
  import mtcs_pkg::*;

  mtcs_st_t          st;
  mtcs_st_t          st_nxt;
  logic [31:0]       crc;
  logic              crc_init;
  logic              crc_en;
  logic [7:0]        crc_byte;
  logic [INT_W-1:0]  int_set;
  logic [INT_W-1:0]  int_clr;
  logic              fin;
  logic              fin_ur;
  logic              fin_mc;
  logic              acc;
  logic              hit;
  logic [15:0]       pad_goal;
  logic [15:0]       cnt_inc;
  logic [31:0]       fcs;

  mtcs_crc32 u_crc (
    .mclk  (mclk),
    .rst_b (rst_b),
    .init  (crc_init),
    .en    (crc_en),
    .data  (crc_byte),
    .crc   (crc)
  );

  assign fcs = ~crc;

  always_comb begin
    st_nxt   = st;
    int_set  = '0;
    int_clr  = '0;
    fin      = 1'b0;
    fin_ur   = 1'b0;
    fin_mc   = 1'b0;
    crc_init = 1'b0;
    crc_en   = 1'b0;
    crc_byte = 8'h00;
    hit      = 1'b0;
    acc      = apb.psel && apb.penable;
    cnt_inc  = st.cnt + 16'h0001;
    pad_goal = st.cur_crc ? (MIN_FRAME - FCS_LEN) : MIN_FRAME;
    st_nxt.tx.valid = 1'b0;
    st_nxt.tx.last  = 1'b0;
    st_nxt.tx.data  = 8'h00;

    // flow control
    st_nxt.near_q    = rx_near_full;
    st_nxt.pause_req = st.ctl_fc && full_duplex && rx_near_full && !st.near_q;
    st_nxt.bkpr      = st.ctl_fc && !full_duplex && rx_near_full;
    if (st_nxt.pause_req) begin
      int_set[INT_PAUSE] = 1'b1;
    end

    // transmit framing
    if (st.state != S_IDLE && coll_late) begin
      st_nxt.lc_seen = 1'b1;
    end
    unique case (st.state)
      S_IDLE: begin
        crc_init = 1'b1;
        st_nxt.cnt     = CNT_RST;
        st_nxt.fcs_idx = 2'h0;
        st_nxt.lc_seen = 1'b0;
        if (st.ctl_run && !st.fatal && qin.valid) begin
          st_nxt.state   = S_DATA;
          st_nxt.q_ready = 1'b1;
          st_nxt.cur_fid = qin.fid;
          st_nxt.cur_crc = st.ctl_crc;
          st_nxt.cur_pad = st.ctl_pad;
        end
      end
      S_DATA: begin
        if (coll_max) begin
          fin_mc = 1'b1;
        end else if (!qin.valid) begin
          fin_ur = 1'b1;
        end else begin
          crc_en          = 1'b1;
          crc_byte        = qin.data;
          st_nxt.tx.valid = 1'b1;
          st_nxt.tx.data  = qin.data;
          st_nxt.cnt      = cnt_inc;
          if (qin.last) begin
            st_nxt.q_ready = 1'b0;
            if (st.cur_pad && cnt_inc < pad_goal) begin
              st_nxt.state = S_PAD;
            end else if (st.cur_crc) begin
              st_nxt.state = S_FCS;
            end else begin
              st_nxt.tx.last = 1'b1;
              fin = 1'b1;
            end
          end
        end
      end
      S_PAD: begin
        if (coll_max) begin
          fin_mc = 1'b1;
        end else begin
          crc_en          = 1'b1;
          st_nxt.tx.valid = 1'b1;
          st_nxt.cnt      = cnt_inc;
          if (cnt_inc >= pad_goal) begin
            if (st.cur_crc) begin
              st_nxt.state = S_FCS;
            end else begin
              st_nxt.tx.last = 1'b1;
              fin = 1'b1;
            end
          end
        end
      end
      S_FCS: begin
        if (coll_max) begin
          fin_mc = 1'b1;
        end else begin
          st_nxt.tx.valid = 1'b1;
          st_nxt.tx.data  = fcs[8*st.fcs_idx +: 8];
          st_nxt.fcs_idx  = st.fcs_idx + 2'h1;
          if (st.fcs_idx == 2'h3) begin
            st_nxt.tx.last = 1'b1;
            fin = 1'b1;
          end
        end
      end
    endcase

    // frame end: status names the frame just finished or dropped
    if (fin || fin_ur || fin_mc) begin
      st_nxt.state   = S_IDLE;
      st_nxt.q_ready = 1'b0;
      st_nxt.txs_fid = st.cur_fid;
      st_nxt.txs_ur  = fin_ur;
      st_nxt.txs_lc  = st.lc_seen || coll_late;
      st_nxt.txs_mc  = fin_mc;
      int_set[INT_DONE] = 1'b1;
      int_set[INT_UR]   = fin_ur;
      int_set[INT_LC]   = st.lc_seen || coll_late;
      int_set[INT_MC]   = fin_mc;
      if (fin_ur) begin
        st_nxt.fatal = 1'b1;
      end
    end

    // apb: one wait state, effects on the completing edge
    unique case (apb.paddr)
      CTL_ADDR, STS_ADDR, INT_ADDR, MSK_ADDR, RUN_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    if (acc && !st.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata  = RD_RST;
      unique case (apb.paddr)
        CTL_ADDR: begin
          st_nxt.prdata[CTL_RUN_BIT] = st.ctl_run;
          st_nxt.prdata[CTL_CRC_BIT] = st.ctl_crc;
          st_nxt.prdata[CTL_PAD_BIT] = st.ctl_pad;
          st_nxt.prdata[CTL_FC_BIT]  = st.ctl_fc;
          st_nxt.prdata[CTL_RSV_LO +: 2] = st.ctl_rsv;
        end
        STS_ADDR: begin
          st_nxt.prdata[STS_FID_LO +: 6] = st.txs_fid;
          st_nxt.prdata[STS_MC_BIT] = st.txs_mc;
          st_nxt.prdata[STS_LC_BIT] = st.txs_lc;
          st_nxt.prdata[STS_UR_BIT] = st.txs_ur;
        end
        INT_ADDR: st_nxt.prdata[INT_W-1:0] = st.int_sts;
        MSK_ADDR: st_nxt.prdata[INT_W-1:0] = st.int_msk;
        RUN_ADDR: begin
          st_nxt.prdata[RUN_ACT_BIT]   = st.state != S_IDLE;
          st_nxt.prdata[RUN_FATAL_BIT] = st.fatal;
          st_nxt.prdata[RUN_EN_BIT]    = st.ctl_run;
        end
        default: st_nxt.prdata = RD_RST;
      endcase
    end else if (acc && st.pready) begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (apb.pwrite) begin
        unique case (apb.paddr)
          CTL_ADDR: begin
            st_nxt.ctl_run = apb.pwdata[CTL_RUN_BIT];
            st_nxt.ctl_crc = apb.pwdata[CTL_CRC_BIT];
            st_nxt.ctl_pad = apb.pwdata[CTL_PAD_BIT];
            st_nxt.ctl_fc  = apb.pwdata[CTL_FC_BIT];
            st_nxt.ctl_rsv = apb.pwdata[CTL_RSV_LO +: 2];
          end
          MSK_ADDR: st_nxt.int_msk = apb.pwdata[INT_W-1:0];
          RUN_ADDR: begin
            if (apb.pwdata[RUN_RESTART_BIT] && !fin_ur) begin
              st_nxt.fatal = 1'b0;
            end
          end
          default: st_nxt.fatal = st_nxt.fatal;
        endcase
      end else if (apb.paddr == INT_ADDR) begin
        int_clr = st.prdata[INT_W-1:0];
      end
    end else begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // sticky events: a set in the clearing cycle survives
    st_nxt.int_sts = (st.int_sts & ~int_clr) | int_set;
    st_nxt.irq     = |(st_nxt.int_sts & st_nxt.int_msk);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st.ctl_run   <= 1'b0;
      st.ctl_crc   <= 1'b0;
      st.ctl_pad   <= 1'b0;
      st.ctl_fc    <= 1'b0;
      st.ctl_rsv   <= 2'h0;
      st.txs_fid   <= FID_RST;
      st.txs_ur    <= 1'b0;
      st.txs_lc    <= 1'b0;
      st.txs_mc    <= 1'b0;
      st.int_sts   <= '0;
      st.int_msk   <= '0;
      st.state     <= S_IDLE;
      st.cnt       <= CNT_RST;
      st.fcs_idx   <= 2'h0;
      st.fatal     <= 1'b0;
      st.lc_seen   <= 1'b0;
      st.cur_fid   <= FID_RST;
      st.cur_crc   <= 1'b0;
      st.cur_pad   <= 1'b0;
      st.near_q    <= 1'b0;
      st.q_ready   <= 1'b0;
      st.tx        <= '0;
      st.pause_req <= 1'b0;
      st.bkpr      <= 1'b0;
      st.irq       <= 1'b0;
      st.prdata    <= RD_RST;
      st.pready    <= 1'b0;
      st.pslverr   <= 1'b0;
    end else begin
      st <= st_nxt;
    end
  end

  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign q_ready      = st.q_ready;
  assign tx           = st.tx;
  assign pause_req    = st.pause_req;
  assign backpressure = st.bkpr;
  assign irq          = st.irq;

  // helper: bytes already sent in the current frame
  logic [15:0] flen;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flen <= CNT_RST;
    end else begin
      flen <= (st.tx.valid && !st.tx.last) ? flen + 16'h0001 : CNT_RST;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  pause_full_dup_a: assert property (pause_req |-> $past(st.ctl_fc && full_duplex && rx_near_full))
    else $error("pause request without flow control in full duplex");
  bkpr_half_dup_a: assert property (backpressure |-> $past(st.ctl_fc && !full_duplex && rx_near_full))
    else $error("back-pressure without flow control in half duplex");
  fc_off_quiet_a: assert property ((!st.ctl_fc) [*2] |-> !pause_req && !backpressure)
    else $error("flow control output while disabled");
  pad_min_len_a: assert property (tx.valid && tx.last && st.cur_pad |-> flen >= 16'h003f)
    else $error("padded frame shorter than minimum");
  crc_tail_a: assert property (st.state == S_FCS && st.fcs_idx == 2'h3 && !coll_max
                               |=> tx.valid && tx.last && st.state == S_IDLE)
    else $error("crc tail not closing the frame");
  run_start_a: assert property (st.state == S_IDLE && st.ctl_run && !st.fatal && qin.valid
                                |=> q_ready && st.state == S_DATA)
    else $error("enabled transmitter did not start");
  stop_idle_a: assert property (st.state == S_IDLE && !st.ctl_run |=> st.state == S_IDLE)
    else $error("stopped transmitter started a frame");
  finish_frame_a: assert property (st.state == S_DATA && !st.ctl_run && qin.valid && !qin.last && !coll_max
                                   |=> st.state == S_DATA && q_ready)
    else $error("frame cut short by clearing enable");
  underrun_flag_a: assert property (st.state == S_DATA && !qin.valid && !coll_max
                                    |=> st.txs_ur && st.fatal && !q_ready ##1 st.fatal)
    else $error("underrun not reported as fatal");
  late_coll_a: assert property (st.state != S_IDLE && coll_late |=> st.lc_seen || st.txs_lc)
    else $error("late collision lost");
  max_coll_a: assert property (st.state != S_IDLE && coll_max |=> st.state == S_IDLE && st.txs_mc && !tx.valid)
    else $error("maximum collision not reported");
  fid_update_a: assert property (st.state != S_IDLE && st_nxt.state == S_IDLE
                                 |=> st.txs_fid == $past(st.cur_fid))
    else $error("frame identifier not updated");
  rsv_zero_a: assert property (pready && $past(apb.paddr) == CTL_ADDR |-> prdata[12:4] == 9'h000)
    else $error("reserved control bits not zero");

  pad_frame_c: cover property (st.state == S_PAD ##[1:80] tx.last);
  underrun_c: cover property (st.state == S_DATA && !qin.valid);
  pause_c: cover property (pause_req);
  max_coll_c: cover property (st.state == S_FCS && coll_max);
endmodule : mtcs_top

// >>> tb/mtcs_phy_model.sv
// model: link partner behind the phy, collects frames and raises collisions
`timescale 1ns/1ps
module mtcs_phy_model (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_b,
  // byte stream from the mac
  input  wire mtcs_pkg::mtcs_tx_t tx,
  // collision commands, byte position, zero for none
  input  wire logic [7:0]         late_at,
  input  wire logic [7:0]         max_at,
  // collisions seen on the medium
  output logic                    coll_late,
  output logic                    coll_max,
  // record of the last frame
  output logic [15:0]             frame_len,
  output logic [15:0]             frame_cnt,
  output logic                    fcs_good
);
  import mtcs_pkg::*;
  logic [7:0]  mem [0:255];
  logic [15:0] pos;
  logic [31:0] crc;

  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h0, d};
    for (int b = 0; b < 8; b++) x = x[0] ? (x >> 1) ^ CRC_POLY : x >> 1;
    return x;
  endfunction : step

  // collisions only while a frame is on the wire
  assign coll_late = tx.valid && late_at != 8'h00 && pos[7:0] == late_at;
  assign coll_max  = tx.valid && max_at != 8'h00 && pos[7:0] == max_at;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pos       <= 16'h0000;
      crc       <= 32'hffffffff;
      frame_len <= 16'h0000;
      frame_cnt <= 16'h0000;
      fcs_good  <= 1'b0;
    end else if (!tx.valid) begin
      // an abandoned frame leaves no trace for the next one
      pos <= 16'h0000;
      crc <= 32'hffffffff;
    end else begin
      mem[pos[7:0]] <= tx.data;
      if (tx.last) begin
        frame_len <= pos + 16'h0001;
        frame_cnt <= frame_cnt + 16'h0001;
        fcs_good  <= step(crc, tx.data) == 32'hdebb20e3;
        pos       <= 16'h0000;
        crc       <= 32'hffffffff;
      end else begin
        pos <= pos + 16'h0001;
        crc <= step(crc, tx.data);
      end
    end
  end
endmodule : mtcs_phy_model

// >>> tb/tb.sv
// testbench: register, framing, status, interrupt and flow control tests
`timescale 1ns/1ps
module tb;
  import mtcs_pkg::*;
  logic          mclk, rst_b, pready, pslverr, q_ready, full_duplex, coll_late, coll_max;
  logic          rx_near_full, pause_req, backpressure, irq, fcs_good;
  logic [31:0]   prdata, r;
  logic [7:0]    late_at, max_at;
  logic [15:0]   frame_len, frame_cnt;
  mtcs_apb_req_t apb_q;
  mtcs_qin_t     qin;
  mtcs_tx_t      tx;
  int            bad_count, n_checks, np, nb;

  mtcs_top dut (.mclk(mclk), .rst_b(rst_b), .apb(apb_q), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .qin(qin), .q_ready(q_ready), .tx(tx), .full_duplex(full_duplex),
    .coll_late(coll_late), .coll_max(coll_max), .rx_near_full(rx_near_full),
    .pause_req(pause_req), .backpressure(backpressure), .irq(irq));
  mtcs_phy_model phy (.mclk(mclk), .rst_b(rst_b), .tx(tx), .late_at(late_at), .max_at(max_at),
    .coll_late(coll_late), .coll_max(coll_max), .frame_len(frame_len), .frame_cnt(frame_cnt),
    .fcs_good(fcs_good));

  always #2 mclk = ~mclk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic e);
    apb_q <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apb_q.penable <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    e  = pslverr;
    apb_q <= '0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rdc

  // one byte per cycle, so the host starves the port only at byte drop; stop at once when the frame is dropped
  task automatic feed(input int n, input logic [5:0] f, input int drop);
    int   i;
    logic on;
    i  = 0;
    on = 1'b0;
    for (int k = 0; k < 400 && i < n; k++) begin
      qin <= '{(i != drop), 8'(i + 1), (i == n - 1), f};
      @(posedge mclk);
      if (coll_max === 1'b1 || (on && q_ready !== 1'b1) || (q_ready === 1'b1 && i == drop)) break;
      if (q_ready === 1'b1) i++;
      on = on | (q_ready === 1'b1);
    end
    qin <= '0;
  endtask : feed

  task automatic frame(input int n, input logic [5:0] f, input int drop, input int el, input logic cf,
                       input logic [31:0] es);
    logic [15:0] c0;
    c0 = frame_cnt;
    feed(n, f, drop);
    for (int k = 0; k < 300 && el != 0 && frame_cnt === c0; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    if (el != 0) begin
      chk(32'(frame_len), el);
      for (int k = 0; k < el - (cf ? 4 : 0); k++) chk(32'(phy.mem[k]), k < n ? 32'(k + 1) : 32'h0);
      if (cf) chk(32'(fcs_good), 32'h1);
    end
    rdc(STS_ADDR, es);
  endtask : frame

  // nothing may start while stopped or fatal
  task automatic stalled;
    qin <= '{1'b1, 8'h00, 1'b0, 6'h00};
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chk(32'(q_ready), 32'h0);
    @(posedge mclk);
    qin <= '0;
  endtask : stalled

  task automatic fc_run(input logic fd);
    np = 0;
    nb = 0;
    full_duplex  <= fd;
    rx_near_full <= 1'b1;
    repeat (10) begin
      @(negedge mclk);
      np += int'(pause_req);
      nb += int'(backpressure);
    end
    @(posedge mclk);
    rx_near_full <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : fc_run

  initial begin
    mclk = 0;
    rst_b = 0;
    apb_q = '0;
    qin = '0;
    full_duplex = 0;
    rx_near_full = 0;
    late_at = 0;
    max_at = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdc(CTL_ADDR, 32'h0);
    rdc(STS_ADDR, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, np[0]);
    chk(32'(np[0]), 32'h1);
    chk(r, 32'h0);
    wr(CTL_ADDR, 32'hffffffff);
    rdc(CTL_ADDR, 32'h600f);
    wr(STS_ADDR, 32'hffff);
    rdc(STS_ADDR, 32'h0);
    $display("test registers done");
    wr(MSK_ADDR, 32'h1f);
    wr(CTL_ADDR, 32'h7);
    frame(10, 6'h05, 99, 64, 1'b1, 32'h05);
    chk(32'(irq), 32'h1);
    rdc(INT_ADDR, 32'h1);
    rdc(INT_ADDR, 32'h0);
    wr(CTL_ADDR, 32'h1);
    frame(8, 6'h3f, 99, 8, 1'b0, 32'h3f);
    wr(CTL_ADDR, 32'h3);
    frame(70, 6'h01, 99, 74, 1'b1, 32'h01);
    $display("test framing done");
    wr(CTL_ADDR, 32'h7);
    late_at <= 8'd20;
    frame(30, 6'h02, 99, 64, 1'b1, 32'h2002);
    late_at <= 8'd0;
    max_at <= 8'd5;
    frame(30, 6'h03, 99, 0, 1'b0, 32'h1003);
    max_at <= 8'd0;
    rdc(INT_ADDR, 32'hd);
    chk(32'(r[INT_MC]), 32'h1);
    frame(30, 6'h04, 10, 0, 1'b0, 32'h4004);
    rdc(RUN_ADDR, 32'h6);
    chk(32'(r[RUN_FATAL_BIT]), 32'h1);
    stalled();
    wr(RUN_ADDR, 32'h1);
    rdc(RUN_ADDR, 32'h4);
    chk(32'(r[RUN_FATAL_BIT]), 32'h0);
    frame(10, 6'h06, 99, 64, 1'b1, 32'h06);
    $display("test status done");
    fork
      frame(40, 6'h07, 99, 64, 1'b1, 32'h07);
      begin
        repeat (10) @(posedge mclk);
        wr(CTL_ADDR, 32'h6);
      end
    join
    stalled();
    $display("test stop done");
    wr(MSK_ADDR, 32'h0);
    apb(1'b0, INT_ADDR, 32'h0, r, np[0]);
    wr(CTL_ADDR, 32'h8);
    fc_run(1'b1);
    chk(np, 1);
    chk(nb, 0);
    chk(32'(irq), 32'h0);
    wr(MSK_ADDR, 32'h10);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(32'(irq), 32'h1);
    @(posedge mclk);
    rdc(INT_ADDR, 32'h10);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(32'(irq), 32'h0);
    @(posedge mclk);
    fc_run(1'b0);
    chk(np, 0);
    chk(32'(nb > 7), 32'h1);
    wr(CTL_ADDR, 32'h0);
    fc_run(1'b1);
    chk(np + nb, 0);
    fc_run(1'b0);
    chk(np + nb, 0);
    $display("test flow control done");
    wr(CTL_ADDR, 32'h600f);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdc(CTL_ADDR, 32'h0);
    rdc(RUN_ADDR, 32'h0);
    $display("test reset done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
